/* src/pm_cap_pkg.sv */
package pm_cap_pkg;
   // configuration byte offsets of the capability header
   localparam logic [7:0] CAP_ID_OFS = 8'hA0;
   localparam logic [7:0] NEXT_PTR_OFS = 8'hA1;
   localparam logic [7:0] CAPS_WORD_OFS = 8'hA2;
   // fixed header values
   localparam logic [7:0] CAP_ID_VAL = 8'h01;
   localparam logic [7:0] NEXT_PTR_VAL = 8'h00;
   // capabilities word field positions
   localparam int COLD_WAKE_BIT = 15;
   localparam int AUX_BIT = 4;
   // reset values of the capabilities word per revision
   localparam logic [15:0] CAPS_RST_V11 = 16'hFE12;
   localparam logic [15:0] CAPS_RST_V10 = 16'hFE11;
   localparam logic [2:0] VERSION_V11 = 3'h2;
   localparam logic [2:0] VERSION_V10 = 3'h1;
   // read-only upper bits 14..9: wake from d3hot..d0, d2 and d1 supported
   localparam logic [5:0] RO_HIGH_BITS = 6'h3F;
   // bit 4 aux supply needed, gated by cold wake, and bit 3 wake needs clock, held constant
   localparam logic AUX_NEEDED_VAL = 1'b1;
   localparam logic WAKE_CLK_VAL = 1'b0;
   // number of bridge functions with their own copy
   localparam int NUM_FUNCS = 2;
endpackage

/* src/pm_capability_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - id byte reads power-management id
// - next pointer always reads zero
// - cold-wake bit writable, resets to one
// - wake-state bits 14..11 read ones
// - bit 10 reads one, d2 supported
// - bit 9 reads one, d1 supported
// - bits 8..6 reserved, read zero
// - init flag bit 5 reads zero
// - aux flag zero when cold-wake cleared
// - wake-needs-clock bit reads constant
// - version field follows selected revision
// - word resets to revision default value
// - each function keeps own word copy
module pm_capability_regs
   import pm_cap_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rev_v11_i, // static strap, high selects revision 1.1
   input wire logic cfg_wr_i, // configuration write strobe, one cycle
   input wire logic cfg_rd_i, // configuration read strobe, one cycle
   input wire logic cfg_func_i, // target function number
   input wire logic [7:0] cfg_addr_i, // dword-aligned byte address
   input wire logic [3:0] cfg_be_i, // byte enables, active high
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o, // registered read data
   output logic cfg_hit_o // registered: last read hit this dword
);
   // capabilities word of each function, one copy per function
   logic [15:0] caps [NUM_FUNCS];
   // address decode of the header dword, bytes a0..a3
   logic hdr_hit;
   // write strobe that reaches the header dword
   logic hdr_wr;
   // read strobe that reaches the header dword
   logic hdr_rd;
   // only the top byte holds a writable bit
   logic top_byte_wr;
   // per-function write enable of the cold-wake flag
   logic [NUM_FUNCS-1:0] func_wr;
   // capabilities word of the addressed function
   logic [15:0] sel_caps;
   // constant low half of the dword: pointer above id
   logic [15:0] hdr_low;
   // whole header dword as the host sees it
   logic [31:0] hdr_dword;
   // next read data and hit flag, loaded on a read strobe
   logic [31:0] nxt_rdata;
   logic nxt_hit;
   // read data register, held until the next read
   logic [31:0] cfg_rdata_ff;
   // hit register, held until the next read
   logic cfg_hit_ff;

   // true when a byte address selects the header dword
   // the address is dword aligned, so only a0 is compared; a1..a3 do not hit
   function automatic logic hdr_match(input logic [7:0] ad);
      return (ad == CAP_ID_OFS);
   endfunction

   // true when the function number selects copy idx
   // only the lowest bit is compared, as there are two functions
   function automatic logic func_match(input logic fn, input int idx);
      return (fn == idx[0]);
   endfunction

   // address decode, shared by both copies and by the read path
   assign hdr_hit = hdr_match(cfg_addr_i);
   assign hdr_wr = cfg_wr_i & hdr_hit;
   assign hdr_rd = cfg_rd_i & hdr_hit;
   // byte 3 carries bit 15 of the word; bytes 0..2 hold no writable bit
   assign top_byte_wr = hdr_wr & cfg_be_i[3];

   // one copy per function; a write reaches only the addressed copy
   generate
      for (genvar f = 0; f < NUM_FUNCS; f++)
      begin : g_func
         // the copy answers only when its own function number is addressed
         assign func_wr[f] = top_byte_wr & func_match(cfg_func_i, f);
         pm_caps_word u_word (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .rev_v11_i(rev_v11_i),
            .cold_wake_we_i(func_wr[f]),
            .cold_wake_wd_i(cfg_wdata_i[31]),
            .caps_o(caps[f])
         );
      end
   endgenerate

   // the id and pointer are constants, so writes to bytes 0..1 vanish
   assign hdr_low = {NEXT_PTR_VAL, CAP_ID_VAL};
   // the read mux picks the addressed function's word
   assign sel_caps = caps[cfg_func_i];
   assign hdr_dword = {sel_caps, hdr_low};
   // unmapped dwords read zero and do not raise the hit flag
   assign nxt_rdata = hdr_hit ? hdr_dword : 32'h0000_0000;
   assign nxt_hit = hdr_hit;

   // read data is flopped so the host samples a stable value;
   // a write never touches it, so it stands until the next read
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cfg_rdata_ff <= 32'h0000_0000;
         cfg_hit_ff <= 1'b0;
      end
      else if (cfg_rd_i)
      begin
         cfg_rdata_ff <= nxt_rdata;
         cfg_hit_ff <= nxt_hit;
      end
   end

   // outputs come straight from the registers
   assign cfg_rdata_o = cfg_rdata_ff;
   assign cfg_hit_o = cfg_hit_ff;

   // the id byte answers every header read
   // a stuck mux here would hide the whole capability list
   a_id_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[7:0] == CAP_ID_VAL)
      else $error("id byte read wrong");

   // the list ends here, so the pointer reads zero
   // a nonzero value would send software walking into junk
   a_ptr_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[15:8] == NEXT_PTR_VAL)
      else $error("next pointer read wrong");

   // the upper half is the addressed function's word
   // a write in the same cycle is seen only by the next read
   a_caps_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[31:16] == $past(sel_caps))
      else $error("caps word read wrong");

   // unmapped dwords read as zero with no hit
   // the host relies on this to skip absent registers
   a_miss_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cfg_rd_i && !hdr_hit) |=> (cfg_rdata_o == 32'h0000_0000) && !cfg_hit_o)
      else $error("unmapped read not zero");

   // a header read raises the hit flag
   // the flag is what tells a wrapper that this block claimed the read
   a_hit_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_hit_o)
      else $error("hit flag missing");

   // the hit flag follows the address of the last read
   // it must not change on a write
   a_hit_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cfg_rd_i |=> cfg_hit_o == $past(hdr_hit))
      else $error("hit flag wrong");

   // without a read strobe the answer stands
   // the host may sample it late, so it must not drift
   a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !cfg_rd_i |=> $stable(cfg_rdata_o) && $stable(cfg_hit_o))
      else $error("read data changed without read");

   // wake from d3hot, d2, d1 and d0 is always advertised
   // these bits sit at 30..27 of the dword
   a_wake_mask: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[30:27] == 4'hF)
      else $error("wake state bits wrong");

   // d2 and d1 support bits read as ones
   // they sit at 26..25 of the dword
   a_low_states: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[26:25] == 2'b11)
      else $error("low state support wrong");

   // reserved bits and the init flag read zero
   // they sit at 24..21 of the dword
   a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[24:21] == 4'h0)
      else $error("reserved bits not zero");

   // the wake-needs-clock bit is a constant
   // it sits at bit 19 of the dword
   a_clock_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[19] == WAKE_CLK_VAL)
      else $error("wake clock bit wrong");

   // the aux flag must read zero once cold wake is cleared
   // checked on the bus as well as inside each copy
   a_aux_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (hdr_rd && !sel_caps[COLD_WAKE_BIT]) |=> !cfg_rdata_o[16 + AUX_BIT])
      else $error("aux flag read without cold wake");

   // the version field follows the strap
   // the strap is static, so its present value is the one to compare
   a_version_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hdr_rd |=> cfg_rdata_o[18:16] == (rev_v11_i ? VERSION_V11 : VERSION_V10))
      else $error("version field read wrong");

   // a write to function 1 leaves function 0 alone
   // guards against a shared enable between the copies
   a_func_isolated: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cfg_wr_i && cfg_func_i) |=> $stable(caps[0]))
      else $error("function 1 write hit function 0");

   // a write to function 0 leaves function 1 alone
   // the mirror case of the check above
   a_func1_isolated: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cfg_wr_i && !cfg_func_i) |=> $stable(caps[1]))
      else $error("function 0 write hit function 1");

   // writes without the top byte enable change nothing
   // bytes 0..2 hold only read-only bits
   a_low_write_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (hdr_wr && !cfg_be_i[3]) |=> $stable(caps[0]) && $stable(caps[1]))
      else $error("low byte write changed a word");

   // a top byte write to function 0 lands in bit 15
   // written data bit 31 carries the new flag
   a_write_lands: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (top_byte_wr && !cfg_func_i) |=> caps[0][COLD_WAKE_BIT] == $past(cfg_wdata_i[31]))
      else $error("cold wake write lost on bus");
endmodule
`default_nettype wire

/* src/pm_caps_word.sv */
`timescale 1ns/1ps
`default_nettype none
// one function's copy of the capabilities word
module pm_caps_word
   import pm_cap_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rev_v11_i,
   input wire logic cold_wake_we_i,
   input wire logic cold_wake_wd_i,
   output logic [15:0] caps_o
);
   logic cold_wake_ff; // only writable bit
   logic [2:0] version; // version field from revision strap
   logic aux_supply_needed; // gated by cold wake flag
   logic rst_cold; // reset value of bit 15 taken from package
   assign version = rev_v11_i ? VERSION_V11 : VERSION_V10;
   assign rst_cold = rev_v11_i ? CAPS_RST_V11[COLD_WAKE_BIT] : CAPS_RST_V10[COLD_WAKE_BIT];
   // aux flag is meaningless without cold wake, so it reads zero then
   assign aux_supply_needed = AUX_NEEDED_VAL & cold_wake_ff;
   // writable wake-from-cold flag; reset value comes from a constant per revision
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cold_wake_ff <= rst_cold;
      end
      else if (cold_wake_we_i)
      begin
         cold_wake_ff <= cold_wake_wd_i;
      end
   end
   // bits 14..9 ones, 8..6 and 5 zero, bit 3 constant
   assign caps_o = {cold_wake_ff, RO_HIGH_BITS, 3'h0, 1'b0, aux_supply_needed, WAKE_CLK_VAL, version};
   // after reset the word equals the documented default for the revision
   a_reset_value: assert property (@(posedge core_clk_i) rst_i |=> (caps_o == (rev_v11_i ? CAPS_RST_V11 : CAPS_RST_V10)))
      else $error("caps word reset value wrong");
   a_aux_gated: assert property (@(posedge core_clk_i) disable iff (rst_i) !caps_o[COLD_WAKE_BIT] |-> !caps_o[AUX_BIT])
      else $error("aux flag set without cold wake");
   a_ro_bits: assert property (@(posedge core_clk_i) disable iff (rst_i) caps_o[14:5] == 10'h3F0)
      else $error("read-only bits wrong");
   a_write_takes: assert property (@(posedge core_clk_i) disable iff (rst_i) cold_wake_we_i |=> caps_o[15] == $past(cold_wake_wd_i))
      else $error("cold wake write lost");
   a_hold_value: assert property (@(posedge core_clk_i) disable iff (rst_i) !cold_wake_we_i |=> $stable(caps_o[15]))
      else $error("cold wake changed without write");
   a_version_field: assert property (@(posedge core_clk_i) disable iff (rst_i) caps_o[2:0] == (rev_v11_i ? VERSION_V11 : VERSION_V10))
      else $error("version field wrong");
endmodule
`default_nettype wire

/* tb/pci_pm_capability_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module pci_pm_capability_regs_test;
   logic clk = 1'b0, rst = 1'b1, rev = 1'b1, wr, rd, fn, hit;
   logic [7:0] a;
   logic [3:0] be;
   logic [31:0] wd, rdata, r;
   logic [1:0] cw; // model of both cold-wake flags
   int err_count = 0, checks = 0;
   initial forever #50 clk = ~clk;
   pm_host_model u_pm_host_model (.clk_i(clk), .wr_o(wr), .rd_o(rd), .fn_o(fn), .a_o(a), .be_o(be), .d_o(wd));
   pm_capability_regs u_pm_capability_regs (.core_clk_i(clk), .rst_i(rst), .rev_v11_i(rev), .cfg_wr_i(wr),
      .cfg_rd_i(rd), .cfg_func_i(fn), .cfg_addr_i(a), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
      .cfg_hit_o(hit));
   // expected {hit, dword}; aux flag follows the cold-wake flag
   function automatic logic [32:0] exp_rd(input logic c, input logic [7:0] ad);
      return (ad == 8'hA0) ? {1'b1, c, 6'h3F, 4'h0, c, 1'b0, rev ? 3'h2 : 3'h1, 16'h0001} : 33'h0;
   endfunction
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t read got %h exp %h", $time, got, exp);
      end
   endtask
   // read answer lands on the edge that takes the strobe, checked just after it
   task automatic rd_chk(input logic f, input logic [7:0] ad);
      u_pm_host_model.xfer(1'b0, f, ad, 4'h0, 32'h0000_0000);
      #1 chk({hit, rdata}, exp_rd(cw[f], ad));
   endtask
   task automatic wr_do(input logic f, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] d);
      u_pm_host_model.xfer(1'b1, f, ad, b, d);
      if (ad == 8'hA0 && b[3]) cw[f] = d[31];
   endtask
   task automatic end_of_test;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // both straps, each after its own reset
   initial
   begin
      void'($urandom(32'h2ac9_8d60));
      for (int p = 0; p < 2; p++)
      begin
         @(posedge clk);
         rst <= 1'b1;
         rev <= (p == 0);
         cw = 2'b11;
         repeat (12) @(posedge clk);
         rst <= 1'b0;
         rd_chk(1'b0, 8'hA0);
         wr_do(1'b0, 8'hA0, 4'hF, 32'h0000_0000);
         rd_chk(1'b0, 8'hA0);
         rd_chk(1'b1, 8'hA0);
         rd_chk(1'b0, 8'hA4);
         repeat (150)
         begin
            r = $urandom;
            wr_do(r[0], r[1] ? 8'hA0 : 8'hA4, r[5:2], $urandom);
            rd_chk(r[6], r[7] ? 8'hA0 : 8'h9C);
         end
      end
      end_of_test;
   end
   // hang guard, far beyond the roughly 1300 cycles needed
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test;
   end
endmodule
`default_nettype wire

/* tb/pm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// config host: one-cycle strobes launched just after a rising edge
module pm_host_model
(
   input wire logic clk_i,
   output logic wr_o,
   output logic rd_o,
   output logic fn_o,
   output logic [7:0] a_o,
   output logic [3:0] be_o,
   output logic [31:0] d_o
);
   initial {wr_o, rd_o, fn_o, a_o, be_o, d_o} = '0;
   // released address and data lines show the inverse, so stale values never pass
   task automatic xfer(input logic w, input logic f, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk_i);
      {wr_o, rd_o, fn_o, a_o, be_o, d_o} <= {w, !w, f, a, b, d};
      @(posedge clk_i);
      {wr_o, rd_o, a_o, d_o} <= {2'b00, ~a, ~d};
   endtask
endmodule
`default_nettype wire
